// ---- twem_master.sv ----
// How it works
// - two-wire select routes clock to pin four, data to pin five
// - firmware sees only a data byte and a control/status register
// - load data byte, write code 0011 to transmit it
// - busy at bit 6 is high during an operation, resets low
// - a one-cycle done interrupt fires whenever busy falls
// - bit 5 resets high, reads low when the EEPROM acknowledged
// - bit 4 resets high, reads low after we drove an acknowledge
// - code 0001 reads a byte, acknowledges, leaves byte in data
// - code 0110 reads a final byte and leaves data released
// - code 0101 makes a STOP condition
// - code 1001 makes a START condition
// - code 0000 stops the clock, which keeps toggling after a START or a byte until 0000 or STOP
// - other codes do nothing on the bus and set error at bit 7
// - clock runs near 78kHz during transfers, high when stopped
`timescale 1ns/1ps
module twem_master
  import twem_pkg::*;
#(
  parameter int QUARTER_CYCLES = twem_pkg::QUARTER_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic [1:0] eeprom_pin_select_i,
  output logic [7:0] eeprom_data_byte_o,
  output logic [7:0] eeprom_control_status_o,
  output logic serial_done_interrupt_o,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n_o,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_n_o
);
  import twem_pkg::*;

  localparam twem_ref_s REF_RESET = '{
    data: DATA_RESET,
    status: STATUS_RESET,
    req_tgl: 1'b0,
    ack_prev: 1'b0,
    irq: 1'b0
  };

  localparam twem_link_s LINK_RESET = '{
    state: LINK_IDLE,
    step: 2'h0,
    bitn: 4'h0,
    cmd: CMD_NOOP,
    shift: 8'h00,
    rx: 8'h00,
    rx_ack: 1'b1,
    run: 1'b0,
    scl: 1'b1,
    sda_low: 1'b0,
    sel: 1'b0,
    scl_oe_n: 1'b1,
    sda_oe_n: 1'b1,
    req_prev: 1'b0,
    ack_tgl: 1'b0
  };

  twem_ref_s r;
  twem_ref_s next_r;
  twem_link_s l;
  twem_link_s next_l;

  logic ack_sync;
  logic req_sync;
  logic [1:0] sel_sync;
  logic sda_sync;
  logic tick;

  // done toggle back into the register domain
  twem_sync #(
    .WIDTH(1)
  ) u_ack_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(l.ack_tgl),
    .q_o(ack_sync)
  );

  // command toggle into the link domain; command and byte sit still
  // in the register domain while busy, so they need no sync of their own
  twem_sync #(
    .WIDTH(1)
  ) u_req_sync (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(r.req_tgl),
    .q_o(req_sync)
  );

  twem_sync #(
    .WIDTH(2)
  ) u_sel_sync (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(eeprom_pin_select_i),
    .q_o(sel_sync)
  );

  twem_sync #(
    .WIDTH(1)
  ) u_sda_sync (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(serial_data_pin_i),
    .q_o(sda_sync)
  );

  twem_tick #(
    .CYCLES(QUARTER_CYCLES)
  ) u_tick (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  function automatic logic legal_cmd(input logic [3:0] c);
    legal_cmd = (c == CMD_NOOP) || (c == CMD_RECV) || (c == CMD_SEND) ||
      (c == CMD_STOP) || (c == CMD_RECV_LAST) || (c == CMD_START);
  endfunction

  // register side
  always_comb
  begin
    next_r = r;
    next_r.irq = 1'b0;
    if (ack_sync != r.ack_prev)
    begin
      next_r.ack_prev = ack_sync;
      next_r.status[BIT_BUSY] = 1'b0;
      next_r.irq = 1'b1;
      case (r.status[3:0])
        CMD_SEND:
        begin
          next_r.status[BIT_RX_ACK] = l.rx_ack;
        end
        CMD_RECV:
        begin
          next_r.data = l.rx;
          next_r.status[BIT_TX_ACK] = 1'b0;
        end
        CMD_RECV_LAST:
        begin
          next_r.data = l.rx;
          next_r.status[BIT_TX_ACK] = 1'b1;
        end
        default:
        begin
          next_r.data = r.data;
        end
      endcase
    end
    // writes while busy are dropped: the link is still using the byte
    if (data_wr_i && !r.status[BIT_BUSY])
      next_r.data = data_wdata_i;
    if (ctrl_wr_i && !r.status[BIT_BUSY])
    begin
      next_r.status[3:0] = ctrl_wdata_i[3:0];
      if (legal_cmd(ctrl_wdata_i[3:0]))
      begin
        next_r.status[BIT_ERROR] = 1'b0;
        next_r.status[BIT_BUSY] = 1'b1;
        next_r.req_tgl = ~r.req_tgl;
      end
      else
        next_r.status[BIT_ERROR] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= REF_RESET;
    else
      r <= next_r;
  end

  // link side
  always_comb
  begin
    next_l = l;
    next_l.sel = (sel_sync == PIN_SEL_TWO_WIRE);
    case (l.state)
      LINK_IDLE:
      begin
        if (req_sync != l.req_prev)
        begin
          next_l.req_prev = req_sync;
          next_l.cmd = r.status[3:0];
          next_l.shift = r.data;
          next_l.step = 2'h0;
          next_l.bitn = 4'h0;
          case (r.status[3:0])
            CMD_NOOP:
            begin
              next_l.run = 1'b0;
              next_l.scl = 1'b1;
              next_l.ack_tgl = ~l.ack_tgl;
            end
            CMD_START:
              next_l.state = LINK_START;
            CMD_STOP:
              next_l.state = LINK_STOP;
            default:
              next_l.state = LINK_BYTE;
          endcase
        end
        else if (tick && l.run)
        begin
          // free running clock, data left untouched
          next_l.step = l.step + 2'h1;
          if (l.step[0])
            next_l.scl = ~l.scl;
        end
      end
      LINK_START:
      begin
        if (tick)
        begin
          next_l.step = l.step + 2'h1;
          case (l.step)
            2'h0:
              next_l.scl = 1'b0;
            2'h1:
              next_l.sda_low = 1'b0;
            2'h2:
              next_l.scl = 1'b1;
            default:
            begin
              // data falls while clock is high
              next_l.sda_low = 1'b1;
              next_l.run = 1'b1;
              next_l.state = LINK_IDLE;
              next_l.ack_tgl = ~l.ack_tgl;
            end
          endcase
        end
      end
      LINK_STOP:
      begin
        if (tick)
        begin
          next_l.step = l.step + 2'h1;
          case (l.step)
            2'h0:
              next_l.scl = 1'b0;
            2'h1:
              next_l.sda_low = 1'b1;
            2'h2:
              next_l.scl = 1'b1;
            default:
            begin
              // data rises while clock is high; clock then rests high
              next_l.sda_low = 1'b0;
              next_l.run = 1'b0;
              next_l.state = LINK_IDLE;
              next_l.ack_tgl = ~l.ack_tgl;
            end
          endcase
        end
      end
      LINK_BYTE:
      begin
        if (tick)
        begin
          next_l.step = l.step + 2'h1;
          case (l.step)
            2'h0:
              next_l.scl = 1'b0;
            2'h1:
            begin
              if (l.bitn != LAST_BIT)
                next_l.sda_low = (l.cmd == CMD_SEND) && !l.shift[7];
              else
                next_l.sda_low = (l.cmd == CMD_RECV);
            end
            2'h2:
              next_l.scl = 1'b1;
            default:
            begin
              // sample one tick into the high phase
              if (l.bitn != LAST_BIT)
              begin
                next_l.shift = {l.shift[6:0], sda_sync};
                next_l.bitn = l.bitn + 4'h1;
              end
              else
              begin
                next_l.rx_ack = sda_sync;
                next_l.rx = l.shift;
                next_l.run = 1'b1;
                next_l.state = LINK_IDLE;
                next_l.ack_tgl = ~l.ack_tgl;
              end
            end
          endcase
        end
      end
      default:
        next_l.state = LINK_IDLE;
    endcase
    next_l.scl_oe_n = ~next_l.sel;
    next_l.sda_oe_n = ~(next_l.sel && next_l.sda_low);
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      l <= LINK_RESET;
    else
      l <= next_l;
  end

  assign eeprom_data_byte_o = r.data;
  assign eeprom_control_status_o = r.status;
  assign serial_done_interrupt_o = r.irq;
  assign serial_clock_pin_o = l.scl;
  assign serial_clock_pin_oe_n_o = l.scl_oe_n;
  // data pin is open drain: only ever pulled low
  assign serial_data_pin_o = 1'b0;
  assign serial_data_pin_oe_n_o = l.sda_oe_n;
endmodule // twem_master

// ---- twem_pkg.sv ----
package twem_pkg;

  localparam logic [3:0] CMD_NOOP = 4'h0;
  localparam logic [3:0] CMD_RECV = 4'h1;
  localparam logic [3:0] CMD_SEND = 4'h3;
  localparam logic [3:0] CMD_STOP = 4'h5;
  localparam logic [3:0] CMD_RECV_LAST = 4'h6;
  localparam logic [3:0] CMD_START = 4'h9;

  localparam int BIT_ERROR = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_RX_ACK = 5;
  localparam int BIT_TX_ACK = 4;

  localparam logic [7:0] STATUS_RESET = 8'h30;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // pin selection code that routes the two-wire bus onto the pins
  localparam logic [1:0] PIN_SEL_TWO_WIRE = 2'h1;

  localparam logic [3:0] LAST_BIT = 4'h8;

  localparam longint SCL_HZ = 78000;
  localparam longint LINK_PERIOD_PS = 15000;
  // four link ticks per serial clock period, rounded down so never slower
  localparam int QUARTER_CYCLES =
    int'(64'd1000000000000 / (LINK_PERIOD_PS * 4 * SCL_HZ));

  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_START,
    LINK_STOP,
    LINK_BYTE
  } twem_link_e;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] status;
    logic req_tgl;
    logic ack_prev;
    logic irq;
  } twem_ref_s;

  typedef struct packed {
    twem_link_e state;
    logic [1:0] step;
    logic [3:0] bitn;
    logic [3:0] cmd;
    logic [7:0] shift;
    logic [7:0] rx;
    logic rx_ack;
    logic run;
    logic scl;
    logic sda_low;
    logic sel;
    logic scl_oe_n;
    logic sda_oe_n;
    logic req_prev;
    logic ack_tgl;
  } twem_link_s;

endpackage

// ---- twem_sync.sv ----
`timescale 1ns/1ps
module twem_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } twem_sync_s;

  twem_sync_s s;
  twem_sync_s next_s;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("twem_sync: WIDTH must be at least 1");
  end

  always_comb
  begin
    next_s.meta = d_i;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign q_o = s.stable;
endmodule // twem_sync

// ---- twem_tick.sv ----
`timescale 1ns/1ps
module twem_tick #(
  parameter int CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  typedef struct packed {
    logic [12:0] count;
    logic tick;
  } twem_tick_s;

  localparam logic [12:0] LAST = 13'(CYCLES - 1);

  twem_tick_s s;
  twem_tick_s next_s;

  if (CYCLES < 2 || CYCLES > 4096)
  begin : g_bad_cycles
    $error("twem_tick: CYCLES must lie in 2..4096");
  end

  always_comb
  begin
    next_s = s;
    next_s.tick = (s.count == LAST);
    if (s.count == LAST)
      next_s.count = '0;
    else
      next_s.count = s.count + 13'h0001;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick_o = s.tick;
endmodule // twem_tick

// ---- twem_assertions.sv ----
`timescale 1ns/1ps
module twem_assertions
  import twem_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic [1:0] eeprom_pin_select_i,
  input wire logic [7:0] eeprom_data_byte_o,
  input wire logic [7:0] eeprom_control_status_o,
  input wire logic serial_done_interrupt_o,
  input wire logic serial_clock_pin_oe_n_o,
  input wire logic serial_data_pin_oe_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic busy;
  logic irq;
  logic take;
  logic legal;
  assign busy = eeprom_control_status_o[BIT_BUSY];
  assign irq = serial_done_interrupt_o;
  assign take = ctrl_wr_i && !busy;
  assign legal = ctrl_wdata_i[3:0] inside {CMD_NOOP, CMD_RECV, CMD_SEND,
    CMD_STOP, CMD_RECV_LAST, CMD_START};
  irq_on_fall_a:
    assert property ($fell(busy) |-> ##[0:1] irq) else $error("no irq");
  irq_pulse_a:
    assert property (irq |-> !busy ##1 !irq) else $error("irq shape");
  busy_start_a:
    assert property (take && legal |=> busy && !eeprom_control_status_o[7])
    else $error("busy missing");
  illegal_cmd_a:
    assert property (take && !legal |=> (eeprom_control_status_o[7] &&
      !busy)[*3]) else $error("illegal code");
  cmd_readback_a:
    assert property (take |=> eeprom_control_status_o[3:0] ==
      $past(ctrl_wdata_i[3:0])) else $error("code readback");
  busy_ignore_a:
    assert property (ctrl_wr_i && busy |=>
      $stable(eeprom_control_status_o[3:0])) else $error("write taken");
  data_write_a:
    assert property (data_wr_i && !busy |=>
      eeprom_data_byte_o == $past(data_wdata_i)) else $error("data write");
  pins_released_a:
    assert property ((eeprom_pin_select_i != PIN_SEL_TWO_WIRE)[*8] |->
      serial_clock_pin_oe_n_o && serial_data_pin_oe_n_o)
    else $error("pins driven");
  cover property (take && ctrl_wdata_i[3:0] == CMD_SEND);
  cover property (take && ctrl_wdata_i[3:0] == CMD_RECV);
  cover property (take && !legal);
endmodule // twem_assertions

// ---- twem_eeprom_model.sv ----
`timescale 1ns/1ps
module twem_eeprom_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic arm_i,
  input wire logic rd_i,
  input wire logic ack_i,
  input wire logic [7:0] byte_i,
  output logic sda_low_o,
  output logic [7:0] got_o,
  output logic seen_o,
  output int per_o
);
  int n = 0;
  realtime last = 0;
  initial sda_low_o = 1'b0;
  // framing restarts only when armed: the clock free-runs between bytes
  always @(posedge scl_i or posedge arm_i)
  begin
    if (arm_i)
      n = 0;
    else
    begin
      if (n < 8)
        got_o = {got_o[6:0], sda_i};
      if (n == 8)
      begin
        seen_o = sda_i;
        per_o = int'($realtime - last);
      end
      last = $realtime;
      n++;
    end
  end
  always @(negedge scl_i)
    sda_low_o <= rd_i ? (n < 8 && !byte_i[7 - n]) : (n == 8 && ack_i);
endmodule // twem_eeprom_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("unexpected %0t: %h not %h", $time, a, b); \
    end \
  end
module tb_top;
  import twem_pkg::*;
  localparam int QC = 4;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic dwr = 1'b0;
  logic cwr = 1'b0;
  logic [7:0] dwd = 8'h00;
  logic [7:0] cwd = 8'h00;
  logic [1:0] sel = PIN_SEL_TWO_WIRE;
  logic arm = 1'b0;
  logic rd = 1'b0;
  logic ack = 1'b0;
  logic [7:0] eb = 8'h00;
  logic [7:0] dout, st, got;
  logic irq, scl_o, scl_oe_n, sda_o, sda_oe_n, low, seen;
  logic ex_err = 1'b0;
  logic ex_rx = 1'b1;
  logic ex_tx = 1'b1;
  int per;
  int fails = 0;
  int total_checks = 0;
  int irqs = 0;
  int starts = 0;
  int stops = 0;
  int sclk = 0;
  // pull-ups on both pins; firmware never bit-bangs them
  wire scl = scl_oe_n | scl_o;
  wire sda = (sda_oe_n | sda_o) & ~low;
  always #12.5 clk = ~clk;
  initial #3 forever #7.5 lclk = ~lclk;
  // counted away from the edge that launches the pulse
  always @(negedge clk) if (irq === 1'b1) irqs++;
  always @(posedge scl) sclk++;
  always @(negedge sda) if (scl) starts++;
  always @(posedge sda) if (scl) stops++;
  twem_master #(.QUARTER_CYCLES(QC)) i_twem_master (.ref_clk_i(clk),
    .rst_n_i(rst_n), .link_clk_i(lclk), .data_wr_i(dwr),
    .data_wdata_i(dwd), .ctrl_wr_i(cwr), .ctrl_wdata_i(cwd),
    .eeprom_pin_select_i(sel), .eeprom_data_byte_o(dout),
    .eeprom_control_status_o(st), .serial_done_interrupt_o(irq),
    .serial_clock_pin_o(scl_o), .serial_clock_pin_oe_n_o(scl_oe_n),
    .serial_data_pin_i(sda), .serial_data_pin_o(sda_o),
    .serial_data_pin_oe_n_o(sda_oe_n));
  twem_eeprom_model i_twem_eeprom_model (.scl_i(scl), .sda_i(sda),
    .arm_i(arm), .rd_i(rd), .ack_i(ack), .byte_i(eb), .sda_low_o(low),
    .got_o(got), .seen_o(seen), .per_o(per));
  function automatic logic legal(input logic [3:0] c);
    return c inside {CMD_NOOP, CMD_RECV, CMD_SEND, CMD_STOP,
      CMD_RECV_LAST, CMD_START};
  endfunction
  task automatic tick;
    @(posedge clk);
    #2;
  endtask
  task automatic cmd(input logic [3:0] c);
    int i;
    int n0;
    n0 = irqs;
    tick();
    cwr = 1'b1;
    cwd = {4'($urandom), c};
    tick();
    // for legal codes strobes held one more cycle: writes while busy must be ignored
    cwr = legal(c);
    dwr = legal(c);
    cwd = 8'($urandom);
    dwd = 8'($urandom);
    tick();
    cwr = 1'b0;
    dwr = 1'b0;
    for (i = 0; i < 3000 && st[BIT_BUSY] !== 1'b0; i++)
      tick();
    repeat (2) tick();
    ex_err = !legal(c);
    `CHK(st, {ex_err, 1'b0, ex_rx, ex_tx, c})
    `CHK(irqs, n0 + int'(legal(c)))
  endtask
  task automatic xfer(input logic [3:0] c, input logic a);
    int k;
    eb = 8'($urandom);
    rd = c != CMD_SEND;
    ack = a;
    arm = 1'b1;
    tick();
    arm = 1'b0;
    dwr = !rd;
    dwd = eb;
    tick();
    dwr = 1'b0;
    ex_rx = rd ? ex_rx : !a;
    ex_tx = rd ? c == CMD_RECV_LAST : ex_tx;
    cmd(c);
    `CHK(dout, eb)
    `CHK(per, 4 * QC * 15)
    `CHK(rd ? seen : got, rd ? c == CMD_RECV_LAST : eb)
    // clock keeps toggling after the byte, period four quarter ticks
    k = sclk;
    repeat (20) tick();
    `CHK((sclk - k >= 2) && (sclk - k <= 3), 1'b1)
    cmd(CMD_NOOP);
    k = sclk;
    repeat (4)
    begin
      repeat (3) tick();
      `CHK(scl, 1'b1)
    end
    `CHK(sclk, k)
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #300us;
    fails++;
    complete_run();
  end
  initial
  begin
    void'($urandom(32'hC8FB));
    repeat (4) @(posedge clk);
    #2;
    rst_n = 1'b1;
    `CHK(st, STATUS_RESET)
    `CHK(dout, DATA_RESET)
    starts = 0;
    stops = 0;
    cmd(CMD_START);
    `CHK(starts, 1)
    cmd(CMD_NOOP);
    xfer(CMD_SEND, 1'b1);
    xfer(CMD_SEND, 1'b0);
    xfer(CMD_RECV, 1'b0);
    xfer(CMD_RECV_LAST, 1'b0);
    cmd(CMD_STOP);
    `CHK(stops, 1)
    for (int c = 0; c < 16; c++)
      if (!legal(4'(c)))
        cmd(4'(c));
    cmd(CMD_NOOP);
    sel = 2'h0;
    repeat (20) tick();
    `CHK({scl_oe_n, sda_oe_n}, 2'h3)
    complete_run();
  end
endmodule // tb_top
bind twem_master twem_assertions i_twem_assertions (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .data_wr_i(data_wr_i),
  .data_wdata_i(data_wdata_i), .ctrl_wr_i(ctrl_wr_i),
  .ctrl_wdata_i(ctrl_wdata_i), .eeprom_pin_select_i(eeprom_pin_select_i),
  .eeprom_data_byte_o(eeprom_data_byte_o),
  .eeprom_control_status_o(eeprom_control_status_o),
  .serial_done_interrupt_o(serial_done_interrupt_o),
  .serial_clock_pin_oe_n_o(serial_clock_pin_oe_n_o),
  .serial_data_pin_oe_n_o(serial_data_pin_oe_n_o));
